// *** core/cop_params.svh ***
// Constants for the cell overcharge protection state logic.
// Assumes a 20 MHz system clock and comparator inputs already synchronous.
`ifndef COP_PARAMS_SVH
`define COP_PARAMS_SVH

// ****************************************
// Timing
// ****************************************
`define COP_CLK_HZ            20000000
`define COP_OSC_HZ            8000
// Oscillator tick period in system clocks (20 MHz / 8 kHz)
`define COP_OSC_DIV           (`COP_CLK_HZ / `COP_OSC_HZ)
// Overcharge delay in milliseconds, nominal 1.0 s
`define COP_OVCHG_DELAY_MS    1000
// Oscillator ticks making up the overcharge delay
`define COP_OVCHG_TICKS       ((`COP_OVCHG_DELAY_MS * `COP_OSC_HZ) / 1000)
`define COP_DIV_W             12
`define COP_TICK_W            14

`endif

// *** core/cop_pkg.sv ***
// Types for the cell overcharge protection state logic.
// Assumes cop_params.svh is compiled alongside.
package cop_pkg;

  typedef enum logic [1:0] {
    COP_ST_STARTUP,
    COP_ST_NORMAL,
    COP_ST_OVERCHARGE
  } cop_state_t;

endpackage : cop_pkg

// *** core/cop_fsm.sv ***
// Overview of operation
// - Normal status enables both charge and discharge switches.
// - Voltage above overcharge threshold for full delay disables charging, enters overcharge.
// - In overcharge, both sense pin resistors are disconnected.
// - Sense in normal window: release when voltage falls below release threshold.
// - Load attached: release when voltage falls below detect threshold.
// - Startup keeps discharge off until sense pin enters normal window.
// - Discharge overcurrent and short detection held off above overcharge threshold.
// - Charger attached: hold overcharge until sense pin rises above charge threshold.
// - Delays counted in ticks of an 8 kHz internal oscillator.
// - Overcharge detection delay is nominally one second.
//
// Protection state machine; comparator inputs are synchronous levels from
// the analog front end. The startup, normal and overcharge statuses are all covered.
`timescale 1ns/1ps
`include "cop_params.svh"

module cop_fsm #(
  // Tick period in clocks; only a simulation may shorten it
  parameter int OSC_DIV = `COP_OSC_DIV
) (
  input  wire logic CLOCK,
  input  wire logic RSTN,
  input  wire logic ABOVE_OVCHG_DETECT,     // Battery above overcharge detect threshold
  input  wire logic BELOW_OVCHG_RELEASE,    // Battery below overcharge release threshold
  input  wire logic ABOVE_OVDCHG_DETECT,    // Battery above over-discharge threshold
  input  wire logic SENSE_GE_CHG_OC,        // Load sense pin at/above charge OC threshold
  input  wire logic SENSE_GE_DCHG_OC,       // Load sense pin at/above discharge OC threshold
  output logic      CHARGE_EN,
  output logic      DISCHARGE_EN,
  output logic      PULLUP_EN,
  output logic      PULLDOWN_EN,
  output logic      DCHG_OC_DETECT_EN,
  output logic      IN_OVERCHARGE
);

  // ****************************************
  // Oscillator tick and delay counter
  // ****************************************
  logic [`COP_DIV_W-1:0]  div_ff;
  logic                   tick_ff;
  logic [`COP_TICK_W-1:0] dly_ff;
  logic                   armed_ff;
  cop_pkg::cop_state_t    state_ff;
  cop_pkg::cop_state_t    nxt_state;

  function automatic logic in_window(input logic ge_chg, input logic ge_dchg);
    in_window = ge_chg && !ge_dchg;
  endfunction : in_window

  logic normal_ok;
  logic dly_done;
  assign normal_ok = ABOVE_OVDCHG_DETECT && !ABOVE_OVCHG_DETECT
                     && in_window(SENSE_GE_CHG_OC, SENSE_GE_DCHG_OC);
  assign dly_done  = tick_ff && (dly_ff == `COP_TICK_W'(`COP_OVCHG_TICKS - 1));

  // Stand-in for the slow on-chip oscillator: a divided system clock
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (div_ff == `COP_DIV_W'(OSC_DIV - 1)) begin
      div_ff  <= '0;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + `COP_DIV_W'(1);
      tick_ff <= 1'b0;
    end
  end

  // Counts only while the excursion is continuous
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      dly_ff   <= '0;
      armed_ff <= 1'b0;
    end else if (state_ff != cop_pkg::COP_ST_NORMAL || !ABOVE_OVCHG_DETECT) begin
      dly_ff   <= '0;
      armed_ff <= 1'b0;
    end else begin
      armed_ff <= 1'b1;
      if (tick_ff && armed_ff) begin
        dly_ff <= dly_ff + `COP_TICK_W'(1);
      end
    end
  end

  // ****************************************
  // Status machine
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      cop_pkg::COP_ST_STARTUP: begin
        if (normal_ok) begin
          nxt_state = cop_pkg::COP_ST_NORMAL;
        end
      end
      cop_pkg::COP_ST_NORMAL: begin
        if (armed_ff && ABOVE_OVCHG_DETECT && dly_done) begin
          nxt_state = cop_pkg::COP_ST_OVERCHARGE;
        end
      end
      cop_pkg::COP_ST_OVERCHARGE: begin
        // Charger pulls sense below charge OC: hold regardless of voltage
        if (!SENSE_GE_CHG_OC) begin
          nxt_state = cop_pkg::COP_ST_OVERCHARGE;
        end else if (SENSE_GE_DCHG_OC) begin
          if (!ABOVE_OVCHG_DETECT) begin
            nxt_state = cop_pkg::COP_ST_NORMAL;
          end
        end else if (BELOW_OVCHG_RELEASE) begin
          nxt_state = cop_pkg::COP_ST_NORMAL;
        end
      end
      default: nxt_state = cop_pkg::COP_ST_STARTUP;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= cop_pkg::COP_ST_STARTUP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // Switch and resistor enables, registered
  // ****************************************
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      CHARGE_EN     <= 1'b0;
      DISCHARGE_EN  <= 1'b0;
      PULLUP_EN     <= 1'b0;
      PULLDOWN_EN   <= 1'b0;
      IN_OVERCHARGE <= 1'b0;
    end else begin
      CHARGE_EN     <= (nxt_state == cop_pkg::COP_ST_NORMAL);
      DISCHARGE_EN  <= (nxt_state != cop_pkg::COP_ST_STARTUP);
      // Both sense resistors left floating in overcharge
      PULLUP_EN     <= 1'b0;
      PULLDOWN_EN   <= 1'b0;
      IN_OVERCHARGE <= (nxt_state == cop_pkg::COP_ST_OVERCHARGE);
    end
  end

  // Heavy load cannot trip overcurrent while the cell sits above threshold
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      DCHG_OC_DETECT_EN <= 1'b0;
    end else begin
      DCHG_OC_DETECT_EN <= !ABOVE_OVCHG_DETECT;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_in_over;
    state_ff == cop_pkg::COP_ST_OVERCHARGE;
  endsequence

  property p_normal_both_on;
    @(posedge CLOCK) disable iff (!RSTN)
    state_ff == cop_pkg::COP_ST_NORMAL |-> CHARGE_EN && DISCHARGE_EN;
  endproperty
  a_normal_both_on: assert property (p_normal_both_on) else $error("Normal without charge");

  property p_enter_over;
    @(posedge CLOCK) disable iff (!RSTN)
    state_ff == cop_pkg::COP_ST_NORMAL && dly_done && armed_ff && ABOVE_OVCHG_DETECT
      |=> s_in_over and (!CHARGE_EN && DISCHARGE_EN);
  endproperty
  a_enter_over: assert property (p_enter_over) else $error("Overcharge not entered");

  property p_res_off;
    @(posedge CLOCK) disable iff (!RSTN)
    s_in_over |=> !PULLUP_EN && !PULLDOWN_EN;
  endproperty
  a_res_off: assert property (p_res_off) else $error("Sense resistor on");

  property p_rel_window;
    @(posedge CLOCK) disable iff (!RSTN)
    s_in_over and (SENSE_GE_CHG_OC && !SENSE_GE_DCHG_OC && BELOW_OVCHG_RELEASE)
      |=> state_ff == cop_pkg::COP_ST_NORMAL;
  endproperty
  a_rel_window: assert property (p_rel_window) else $error("Release path missed");

  property p_rel_load;
    @(posedge CLOCK) disable iff (!RSTN)
    s_in_over and (SENSE_GE_CHG_OC && SENSE_GE_DCHG_OC && !ABOVE_OVCHG_DETECT)
      |=> state_ff == cop_pkg::COP_ST_NORMAL;
  endproperty
  a_rel_load: assert property (p_rel_load) else $error("Load release missed");

  property p_startup;
    @(posedge CLOCK) disable iff (!RSTN)
    state_ff == cop_pkg::COP_ST_STARTUP && !normal_ok |=> !DISCHARGE_EN;
  endproperty
  a_startup: assert property (p_startup) else $error("Discharge on in startup");

  property p_oc_hold;
    @(posedge CLOCK) disable iff (!RSTN)
    ABOVE_OVCHG_DETECT |=> !DCHG_OC_DETECT_EN;
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("OC detect active");

  property p_chg_hold;
    @(posedge CLOCK) disable iff (!RSTN)
    s_in_over and !SENSE_GE_CHG_OC |=> s_in_over and IN_OVERCHARGE;
  endproperty
  a_chg_hold: assert property (p_chg_hold) else $error("Released with charger");

  property p_restart;
    @(posedge CLOCK) disable iff (!RSTN)
    state_ff == cop_pkg::COP_ST_NORMAL && !ABOVE_OVCHG_DETECT |=> dly_ff == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("Delay not restarted");

  // Count never runs past the detection point while still normal
  property p_dly_bound;
    @(posedge CLOCK) disable iff (!RSTN)
    state_ff == cop_pkg::COP_ST_NORMAL |-> dly_ff < `COP_TICK_W'(`COP_OVCHG_TICKS);
  endproperty
  a_dly_bound: assert property (p_dly_bound) else $error("Delay count overrun");

endmodule : cop_fsm

// *** testbench/cop_cmp_model.sv ***
// Comparator front end model: cell level and sense pin mode to threshold flags.
// Assumes the bench drives the cell level in millivolts and a sense mode.
`timescale 1ns/1ps
module cop_cmp_model #(
  parameter int DET_MV  = 4300,
  parameter int REL_MV  = 4200,
  parameter int ODIS_MV = 2500
) (
  input  wire logic [12:0] cell_mv,
  input  wire logic [1:0]  sense_mode,  // 0 charger, 1 window, 2 load
  output logic             above_det,
  output logic             below_rel,
  output logic             above_odis,
  output logic             ge_chg,
  output logic             ge_dchg
);
  assign above_det  = (cell_mv > DET_MV);
  assign below_rel  = (cell_mv < REL_MV);
  assign above_odis = (cell_mv > ODIS_MV);
  // Charger pulls the pin below both thresholds, a load lifts it above both
  assign ge_chg     = (sense_mode != 2'h0);
  assign ge_dchg    = (sense_mode == 2'h2);
endmodule : cop_cmp_model

// *** testbench/cell_overcharge_protection_fsm_tb.sv ***
// Self-checking bench for the protection state logic.
// Assumes a shortened tick period; the run spans about 44k clocks.
`timescale 1ns/1ps
`include "cop_params.svh"
module cell_overcharge_protection_fsm_tb;
  // Fast tick stand-in keeps the full tick count inside a short run
  localparam int OSC_DIV_TB = 2;
  localparam int DLY_CYC    = `COP_OVCHG_TICKS * OSC_DIV_TB;
  logic        CLOCK;
  logic        RSTN;
  logic [12:0] mv;
  logic [1:0]  sm;
  logic        a_det, b_rel, a_odis, s_chg, s_dchg;
  logic        chg, dis, pu, pd, oc_en, in_oc;
  int          miscompares = 0;
  int          samples_checked = 0;

  cop_cmp_model mdl_u (.cell_mv(mv), .sense_mode(sm), .above_det(a_det), .below_rel(b_rel),
    .above_odis(a_odis), .ge_chg(s_chg), .ge_dchg(s_dchg));
  cop_fsm #(.OSC_DIV(OSC_DIV_TB)) dut_u (.CLOCK(CLOCK), .RSTN(RSTN),
    .ABOVE_OVCHG_DETECT(a_det),
    .BELOW_OVCHG_RELEASE(b_rel), .ABOVE_OVDCHG_DETECT(a_odis), .SENSE_GE_CHG_OC(s_chg),
    .SENSE_GE_DCHG_OC(s_dchg), .CHARGE_EN(chg), .DISCHARGE_EN(dis), .PULLUP_EN(pu),
    .PULLDOWN_EN(pd), .DCHG_OC_DETECT_EN(oc_en), .IN_OVERCHARGE(in_oc));

  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic step(input logic [12:0] v, input logic [1:0] m, input int n);
    @(posedge CLOCK);
    mv <= v;
    sm <= m;
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : step

  task automatic close_out;
    $display("compares=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_start;
    step(13'h0ed8, 2'h0, 5);  // 3800 mV, charger pulling pin low
    chk(dis, 1'b0);
    step(13'h0ed8, 2'h1, 2);
    chk(dis, 1'b1);
    chk(chg, 1'b1);
    chk(oc_en, 1'b1);
  endtask : t_start

  task automatic t_glitch;
    step(13'h1130, 2'h1, DLY_CYC * 3 / 4);  // 4400 mV, three quarters of the delay
    chk(oc_en, 1'b0);
    chk(in_oc, 1'b0);
    step(13'h0ed8, 2'h1, 2);
    chk(chg, 1'b1);
    chk(oc_en, 1'b1);
  endtask : t_glitch

  // Window of 0.8 to 1.2 of the nominal delay; a stale count trips early
  task automatic t_enter;
    int n;
    step(13'h1130, 2'h1, DLY_CYC * 8 / 10);
    chk(in_oc, 1'b0);
    for (n = 0; n < DLY_CYC * 4 / 10 && in_oc !== 1'b1; n++) begin
      @(posedge CLOCK);
      #1;
    end
    chk(in_oc, 1'b1);
    chk(chg, 1'b0);
    chk(dis, 1'b1);
    chk(pu, 1'b0);
    chk(pd, 1'b0);
    chk(oc_en, 1'b0);
  endtask : t_enter

  task automatic t_charger;
    step(13'h0fa0, 2'h0, 20);  // 4000 mV with charger attached
    chk(in_oc, 1'b1);
    step(13'h0fa0, 2'h1, 2);
    chk(in_oc, 1'b0);
    chk(chg, 1'b1);
  endtask : t_charger

  task automatic t_load;
    step(13'h109a, 2'h1, 20);  // 4250 mV, between the two thresholds
    chk(in_oc, 1'b1);
    step(13'h109a, 2'h2, 2);
    chk(in_oc, 1'b0);
    chk(oc_en, 1'b1);
  endtask : t_load

  // Mid-run reset from normal with a load attached
  task automatic t_reset;
    @(posedge CLOCK);
    RSTN <= 1'b0;
    @(posedge CLOCK);
    #1;
    chk(dis, 1'b0);
    chk(in_oc, 1'b0);
    @(posedge CLOCK);
    RSTN <= 1'b1;
    step(13'h109a, 2'h2, 3);
    chk(dis, 1'b0);
    chk(chg, 1'b0);
    step(13'h0ed8, 2'h1, 2);
    chk(dis, 1'b1);
  endtask : t_reset

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (5 * DLY_CYC) @(posedge CLOCK);
    miscompares++;
    close_out();
  end

  initial begin
    RSTN = 1'b0;
    mv = 13'h0ed8;
    sm = 2'h0;
    @(posedge CLOCK);
    #1;
    chk(dis, 1'b0);
    chk(chg, 1'b0);
    @(posedge CLOCK);
    RSTN <= 1'b1;
    t_start();
    t_glitch();
    t_enter();
    t_charger();
    t_enter();
    t_load();
    t_reset();
    close_out();
  end
endmodule : cell_overcharge_protection_fsm_tb
